/* File: design/wsr_pkg.sv */
// Constants, register map and state types for the supervision timer and system reset block.
// Assumes a single 200 MHz clock and an Avalon-MM slave with byte addresses.
package wsr_pkg;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;

    localparam logic [7:0] ADR_CTRL = 8'h00;
    localparam logic [7:0] ADR_WDP = 8'h04;
    localparam logic [7:0] ADR_SWAIT = 8'h08;
    localparam logic [7:0] ADR_DSEL = 8'h0c;
    localparam logic [7:0] ADR_PW = 8'h10;
    localparam logic [7:0] ADR_RSEL = 8'h14;
    localparam logic [7:0] ADR_GSEL = 8'h18;
    localparam logic [7:0] ADR_KICK = 8'h1c;
    localparam logic [7:0] ADR_STAT = 8'h20;
    localparam logic [7:0] ADR_MASK = 8'h24;
    localparam logic [7:0] ADR_STATE = 8'h28;
    localparam logic [7:0] ADR_WCNT = 8'h2c;

    localparam int CB_WD_EN = 0;
    localparam int CB_ROUTE_RST = 1;
    localparam int CB_PULSE = 2;
    localparam int CB_WAIT_EN = 3;
    localparam int CB_TRACK = 4;
    localparam int CB_KICK_PIN = 5;
    localparam int CB_TO_PIN = 6;

    localparam int SB_TIMEOUT = 0;
    localparam int SB_RST_ASSERT = 1;
    localparam int SB_RST_RELEASE = 2;
    localparam int NSTAT = 3;

    localparam logic [7:0] CTRL_RST = 8'h60;
    localparam logic [17:0] WDP_RST = 18'h003e8;
    localparam logic [3:0] SWAIT_RST = 4'h0;
    localparam logic [4:0] DSEL_RST = 5'h00;
    localparam logic [15:0] PW_RST = 16'h0001;
    localparam logic [23:0] RSEL_RST = 24'h000000;
    localparam logic [7:0] GSEL_RST = 8'h00;
    localparam logic [2:0] MASK_RST = 3'h0;

    localparam logic [20:0] START_BASE_MS = 21'h000064;
    localparam logic [3:0] START_SEL_MAX = 4'he;
    localparam logic [4:0] DLY_SEL_MAX = 5'h10;
    localparam logic [16:0] RECFG_HOLD_MS = 17'h00001;
    localparam int unsigned TO_PULSE_MS = 1;

    typedef enum logic [1:0] {WD_OFF, WD_WAIT, WD_RUN, WD_TOUT} wsr_wd_state_t;
    typedef enum logic [2:0] {RS_HOLD, RS_DELAY, RS_RUN, RS_PULSE, RS_PWAIT} wsr_rs_state_t;
endpackage : wsr_pkg

/* File: design/wsr_tick.sv */
// One-millisecond tick divider for the supervision and reset counters.
// Assumes the main clock runs continuously; TICK_CYC is at least one.
`timescale 1ns/1ps
`default_nettype none
module wsr_tick #(
    parameter int unsigned TICK_CYC = 200000
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    output logic o_tick
);
    logic [31:0] cnt_q;
    wire last = (cnt_q == 32'(TICK_CYC - 1));

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            cnt_q <= 32'h0;
            o_tick <= 1'b0;
        end else begin
            cnt_q <= last ? 32'h0 : cnt_q + 32'h1;
            o_tick <= last;
        end
    end
endmodule : wsr_tick
`default_nettype wire

/* File: design/wsr_top.sv */
// Supervision timer and system reset generator with an Avalon-MM register slave.
// Assumes all inputs are synchronous to i_mclk; rail and input conditions come as levels.
//
// Design decisions made here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module wsr_top import wsr_pkg::*; #(
    parameter int unsigned TICK_CYC = TICK_CYCLES,
    parameter int unsigned TO_PULSE_TICKS = TO_PULSE_MS
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic [7:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [3:0] i_byteenable,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    output logic o_irq,
    input wire logic i_kick,
    input wire logic [23:0] i_pg_on,
    input wire logic [23:0] i_pg_off,
    input wire logic [7:0] i_gpi,
    output logic o_timeout,
    output logic o_sys_rst_n
);
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [31:0] m);
        return (o & ~m) | (n & m);
    endfunction : merge

    // Start wait is 100 ms doubled sel times, sel capped at 14.
    function automatic logic [20:0] start_ms(input logic [3:0] sel);
        logic [3:0] s;
        s = (sel > START_SEL_MAX) ? START_SEL_MAX : sel;
        return START_BASE_MS << s;
    endfunction : start_ms

    // Release delay is zero for sel 0, else 1 ms doubled sel-1 times, sel capped at 16.
    function automatic logic [16:0] dly_ms(input logic [4:0] sel);
        logic [4:0] s;
        s = (sel > DLY_SEL_MAX) ? DLY_SEL_MAX : sel;
        return (s == 5'h00) ? 17'h00000 : (17'h00001 << (s - 5'h01));
    endfunction : dly_ms

    logic tick;
    wsr_tick #(.TICK_CYC(TICK_CYC)) u_tick (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .o_tick(tick)
    );

    logic [7:0] ctrl_q;
    logic [17:0] wdp_q;
    logic [3:0] swait_q;
    logic [4:0] dsel_q;
    logic [15:0] pw_q;
    logic [23:0] rsel_q;
    logic [7:0] gsel_q;
    logic [2:0] stat_q, stat_d, mask_q;
    logic kick_prev_q, kick_vld_q;
    wsr_wd_state_t wd_q, wd_d;
    wsr_rs_state_t rs_q, rs_d;
    logic [20:0] wcnt_q, wcnt_d;
    logic [16:0] rcnt_q, rcnt_d;
    logic [7:0] tp_q, tp_d;
    logic to_evt;

    // Bus slave: one wait cycle, accept when waitrequest is low.
    wire acc = (i_read | i_write) & ~o_waitrequest;
    wire wr = acc & i_write;
    wire [31:0] bem = {{8{i_byteenable[3]}}, {8{i_byteenable[2]}},
                       {8{i_byteenable[1]}}, {8{i_byteenable[0]}}};
    wire [31:0] rd_mux =
        (i_address == ADR_CTRL) ? {24'h0, ctrl_q} :
        (i_address == ADR_WDP) ? {14'h0, wdp_q} :
        (i_address == ADR_SWAIT) ? {28'h0, swait_q} :
        (i_address == ADR_DSEL) ? {27'h0, dsel_q} :
        (i_address == ADR_PW) ? {16'h0, pw_q} :
        (i_address == ADR_RSEL) ? {8'h0, rsel_q} :
        (i_address == ADR_GSEL) ? {24'h0, gsel_q} :
        (i_address == ADR_STAT) ? {29'h0, stat_q} :
        (i_address == ADR_MASK) ? {29'h0, mask_q} :
        (i_address == ADR_STATE) ? {26'h0, rs_q, o_timeout, o_sys_rst_n, 1'b0} :
        (i_address == ADR_WCNT) ? {11'h0, wcnt_q} : 32'h0;
    wire [31:0] wnew = merge(rd_mux, i_writedata, bem);
    wire wr_ctrl = wr & (i_address == ADR_CTRL);
    wire wr_stat = wr & (i_address == ADR_STAT);
    wire cfg_wr = wr & ((i_address == ADR_CTRL) | (i_address == ADR_DSEL) |
                        (i_address == ADR_PW) | (i_address == ADR_RSEL) |
                        (i_address == ADR_GSEL));

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_waitrequest <= 1'b1;
            o_readdata <= 32'h0;
        end else begin
            o_waitrequest <= ~((i_read | i_write) & o_waitrequest);
            o_readdata <= rd_mux;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_q <= CTRL_RST;
            wdp_q <= WDP_RST;
            swait_q <= SWAIT_RST;
            dsel_q <= DSEL_RST;
            pw_q <= PW_RST;
            rsel_q <= RSEL_RST;
            gsel_q <= GSEL_RST;
            mask_q <= MASK_RST;
        end else if (wr) begin
            if (wr_ctrl) ctrl_q <= wnew[7:0];
            if (i_address == ADR_WDP) wdp_q <= wnew[17:0];
            if (i_address == ADR_SWAIT) swait_q <= wnew[3:0];
            if (i_address == ADR_DSEL) dsel_q <= wnew[4:0];
            if (i_address == ADR_PW) pw_q <= wnew[15:0];
            if (i_address == ADR_RSEL) rsel_q <= wnew[23:0];
            if (i_address == ADR_GSEL) gsel_q <= wnew[7:0];
            if (i_address == ADR_MASK) mask_q <= wnew[2:0];
        end
    end

    // Kick detection: either edge of the pin, or a bus command.
    wire pin_tog = ctrl_q[CB_KICK_PIN] & kick_vld_q & (i_kick ^ kick_prev_q);
    wire cmd_kick = wr & (i_address == ADR_KICK) & i_writedata[0] & i_byteenable[0];
    wire kick = pin_tog | cmd_kick;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            kick_prev_q <= 1'b0;
            kick_vld_q <= 1'b0;
        end else begin
            kick_prev_q <= i_kick;
            kick_vld_q <= 1'b1;
        end
    end

    // Supervision timer.
    wire wd_en = ctrl_q[CB_WD_EN];
    wire route_rst = ctrl_q[CB_ROUTE_RST];
    wire [20:0] period = (wdp_q == 18'h0) ? 21'h1 : {3'h0, wdp_q};
    wire [20:0] wcnt_inc = tick ? wcnt_q + 21'h1 : wcnt_q;

    always_comb begin
        wd_d = wd_q;
        wcnt_d = wcnt_inc;
        to_evt = 1'b0;
        case (wd_q)
            WD_OFF: begin
                wcnt_d = 21'h0;
                if (wd_en) wd_d = ctrl_q[CB_WAIT_EN] ? WD_WAIT : WD_RUN;
            end
            WD_WAIT: begin
                if (wcnt_q >= start_ms(swait_q)) begin
                    wd_d = WD_RUN;
                    wcnt_d = 21'h0;
                end
            end
            WD_RUN: begin
                if (kick) begin
                    wcnt_d = 21'h0;
                end else if (wcnt_q >= period) begin
                    to_evt = 1'b1;
                    wd_d = WD_TOUT;
                end
            end
            WD_TOUT: begin
                if (kick) begin
                    wd_d = WD_RUN;
                    wcnt_d = 21'h0;
                end
            end
            default: wd_d = WD_OFF;
        endcase
        if (!wd_en) begin
            wd_d = WD_OFF;
            wcnt_d = 21'h0;
            to_evt = 1'b0;
        end
    end

    // Timeout pin pulse, only when the pin is assigned and not routed to reset.
    wire to_pin = to_evt & ~route_rst & ctrl_q[CB_TO_PIN];
    always_comb begin
        tp_d = tp_q;
        if (to_pin) tp_d = 8'(TO_PULSE_TICKS);
        else if (tick && tp_q != 8'h0) tp_d = tp_q - 8'h1;
    end

    // System reset generator.
    wire pulse_md = ctrl_q[CB_PULSE];
    wire cond_on = &(i_pg_on | ~rsel_q) & &(i_gpi | ~gsel_q);
    wire cond_bad = |(i_pg_off & rsel_q) | |(~i_gpi & gsel_q);
    wire [16:0] pw_len = (pw_q == 16'h0) ? 17'h1 : {1'b0, pw_q};
    wire [16:0] rcnt_inc = (tick && rcnt_q != 17'h1ffff) ? rcnt_q + 17'h1 : rcnt_q;
    wire released = (rs_q == RS_RUN) | (rs_q == RS_PWAIT);
    wire rst_n_d = (rs_d == RS_RUN) | (rs_d == RS_PWAIT);

    always_comb begin
        rs_d = rs_q;
        rcnt_d = rcnt_inc;
        case (rs_q)
            RS_HOLD: begin
                if (cond_on && rcnt_q >= RECFG_HOLD_MS) begin
                    rs_d = pulse_md ? RS_PULSE : RS_DELAY;
                    rcnt_d = 17'h0;
                end
            end
            RS_DELAY: begin
                if (cond_bad) begin
                    rs_d = RS_HOLD;
                    rcnt_d = 17'h0;
                end else if (rcnt_q >= dly_ms(dsel_q)) begin
                    rs_d = RS_RUN;
                end
            end
            RS_PULSE: begin
                if (rcnt_q >= pw_len) rs_d = RS_RUN;
            end
            RS_RUN: begin
                if (cond_bad) begin
                    rs_d = pulse_md ? RS_PWAIT : RS_HOLD;
                    rcnt_d = 17'h0;
                end
            end
            RS_PWAIT: begin
                if (cond_on) begin
                    rs_d = RS_PULSE;
                    rcnt_d = 17'h0;
                end
            end
            default: rs_d = RS_HOLD;
        endcase
        if (to_evt && route_rst && released) begin
            rs_d = pulse_md ? RS_PULSE : (ctrl_q[CB_TRACK] ? RS_HOLD : RS_DELAY);
            rcnt_d = 17'h0;
        end
        if (cfg_wr) begin
            rs_d = RS_HOLD;
            rcnt_d = 17'h0;
        end
    end

    // Sticky status, set wins over write-one-to-clear.
    wire [2:0] stat_set = {~o_sys_rst_n & rst_n_d, o_sys_rst_n & ~rst_n_d, to_evt};
    wire [2:0] stat_clr = wr_stat ? (i_writedata[2:0] & bem[2:0]) : 3'h0;
    assign stat_d = (stat_q & ~stat_clr) | stat_set;

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            wd_q <= WD_OFF;
            rs_q <= RS_HOLD;
            wcnt_q <= 21'h0;
            rcnt_q <= 17'h0;
            tp_q <= 8'h0;
            stat_q <= 3'h0;
            o_irq <= 1'b0;
            o_timeout <= 1'b0;
            o_sys_rst_n <= 1'b0;
        end else begin
            wd_q <= wd_d;
            rs_q <= rs_d;
            wcnt_q <= wcnt_d;
            rcnt_q <= rcnt_d;
            tp_q <= tp_d;
            stat_q <= stat_d;
            o_irq <= |(stat_d & mask_q);
            o_timeout <= (tp_d != 8'h0);
            o_sys_rst_n <= rst_n_d;
        end
    end

    // Checks.
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    pin_kick_a: assert property (
        (wd_q == WD_RUN) && pin_tog |=> (wcnt_q == 21'h0) && (wd_q == WD_RUN))
        else $error("pin kick did not restart the timer");
    cmd_kick_a: assert property (
        (wd_q == WD_RUN) && cmd_kick |=> (wcnt_q == 21'h0))
        else $error("bus kick did not restart the timer");
    to_pulse_a: assert property (
        to_evt && !route_rst && ctrl_q[CB_TO_PIN] |=> o_timeout && (wd_q == WD_TOUT))
        else $error("timeout did not pulse the timeout output");
    to_unassigned_a: assert property (
        !ctrl_q[CB_TO_PIN] && !o_timeout && !$past(ctrl_q[CB_TO_PIN]) |=> !o_timeout)
        else $error("unassigned timeout pin pulsed");
    restart_a: assert property (
        (wd_q == WD_TOUT) && kick && wd_en |=> (wd_q == WD_RUN) ##1 (wcnt_q <= 21'h1))
        else $error("kick did not restart after timeout");
    release_a: assert property (
        $rose(o_sys_rst_n) && !$past(pulse_md) |-> $past(rs_q == RS_DELAY) && $past(!cond_bad))
        else $error("reset released without a counted delay");
    dly_hold_a: assert property (
        (rs_q == RS_DELAY) && (rcnt_q < dly_ms(dsel_q)) && !to_evt |=> !o_sys_rst_n)
        else $error("reset released before delay ended");
    drop_a: assert property (
        (rs_q == RS_RUN) && cond_bad && !pulse_md |=> !o_sys_rst_n && (rs_q == RS_HOLD))
        else $error("lost condition did not assert reset");
    pulse_w_a: assert property (
        (rs_q == RS_PULSE) && (rcnt_q < pw_len) && !cfg_wr |=> !o_sys_rst_n)
        else $error("reset pulse ended early");
    wd_rst_a: assert property (
        to_evt && route_rst && released && !cfg_wr |=> !o_sys_rst_n)
        else $error("routed timeout did not assert reset");
    recfg_a: assert property (
        cfg_wr |=> !o_sys_rst_n [*2])
        else $error("reconfiguration did not assert reset");
    pwrup_a: assert property (
        $past(i_rst) |-> !o_sys_rst_n)
        else $error("reset output not asserted after power-up");

    timeout_c: cover property (to_evt ##[1:20] kick);
    release_c: cover property ($rose(o_sys_rst_n));
    pulse_c: cover property ((rs_q == RS_PULSE) ##1 (rs_q == RS_RUN));
    wd_reset_c: cover property (to_evt && route_rst && released);
endmodule : wsr_top
`default_nettype wire

/* File: sim/wsr_host.sv */
// Host processor model that kicks the supervision timer by toggling the kick line.
// Assumes the processor is held in reset while the system reset output is low.
`timescale 1ns/1ps
`default_nettype none
module wsr_host #(
    parameter int GAP = 15
) (
    input wire logic i_mclk,
    input wire logic i_en,
    input wire logic i_rst_n,
    output logic o_kick
);
    int cnt = 0;
    logic kick_q = 1'b0;
    assign o_kick = kick_q;
    // A processor held in reset cannot kick, so its kick schedule restarts with it.
    always @(posedge i_mclk) begin
        if (!i_rst_n || !i_en) begin
            cnt <= 0;
        end else if (cnt == GAP - 1) begin
            cnt <= 0;
            kick_q <= ~kick_q;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : wsr_host
`default_nettype wire

/* File: sim/testbench.sv */
// Self-checking bench for wsr_top: registers, reset release, supervision, pulse mode.
// Assumes a 1 ms tick of 10 clocks and the wsr_host model on the kick line.
`timescale 1ns/1ps
`default_nettype none
module testbench import wsr_pkg::*; ;
    localparam int TK = 10;
    logic i_mclk, i_rst, i_read, i_write, host_en, kick;
    logic [7:0] i_address, i_gpi;
    logic [31:0] i_writedata, rd, o_readdata;
    logic [23:0] i_pg_on, i_pg_off;
    logic o_waitrequest, o_irq, o_timeout, o_sys_rst_n;
    int num_errors = 0;
    int n_checks = 0;
    int n;
    int cnt;

    wsr_top #(.TICK_CYC(TK), .TO_PULSE_TICKS(2)) wsr_top_i (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_address(i_address), .i_read(i_read),
        .i_write(i_write), .i_writedata(i_writedata), .i_byteenable(4'hf),
        .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_irq(o_irq),
        .i_kick(kick), .i_pg_on(i_pg_on), .i_pg_off(i_pg_off), .i_gpi(i_gpi),
        .o_timeout(o_timeout), .o_sys_rst_n(o_sys_rst_n));
    wsr_host #(.GAP(15)) wsr_host_i (
        .i_mclk(i_mclk), .i_en(host_en), .i_rst_n(o_sys_rst_n), .o_kick(kick));

    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done

    // One Avalon access; the request stands until the rising edge that sees waitrequest low.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge i_mclk);
        i_address <= a;
        i_writedata <= d;
        i_write <= wr;
        i_read <= ~wr;
        for (k = 0; k < 20; k++) begin
            @(posedge i_mclk);
            if (o_waitrequest === 1'b0) break;
        end
        if (k == 20) begin
            num_errors++;
            $display("FAIL waitrequest expected 0 seen %h", o_waitrequest);
            test_done();
        end
        rd = o_readdata;
        i_write <= 1'b0;
        i_read <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr

    task automatic rdr(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask : rdr

    function automatic logic sig(input int s);
        case (s)
            0: return o_sys_rst_n;
            1: return o_timeout;
            default: return o_irq;
        endcase
    endfunction : sig

    task automatic wait_for(input int s, input logic v, input int max);
        n = 0;
        do begin
            @(negedge i_mclk);
            n++;
        end while (n < max && sig(s) !== v);
        if (sig(s) !== v) begin
            num_errors++;
            $display("FAIL output %0d expected %h seen %h", s, v, sig(s));
            test_done();
        end
    endtask : wait_for

    task automatic t_regs;
        @(negedge i_mclk);
        chk("rst_n at power-up", 32'(o_sys_rst_n), 32'h0);
        rdr(ADR_CTRL);
        chk("ctrl reset", rd, 32'(CTRL_RST));
        rdr(ADR_WDP);
        chk("wdp reset", rd, 32'(WDP_RST));
        rdr(ADR_PW);
        chk("pw reset", rd, 32'(PW_RST));
        rdr(8'h30);
        chk("unmapped read", rd, 32'h0);
        $display("test regs done");
    endtask : t_regs

    task automatic t_release;
        wr(ADR_DSEL, 32'h3);
        wr(ADR_GSEL, 32'h1);
        repeat (80) @(negedge i_mclk);
        chk("held without input", 32'(o_sys_rst_n), 32'h0);
        @(posedge i_mclk);
        i_gpi <= 8'h01;
        wait_for(0, 1'b1, 100);
        chk("4 ms delay", 32'(n >= 30), 32'h1);
        @(posedge i_mclk);
        i_gpi <= 8'h00;
        wait_for(0, 1'b0, 4);
        wr(ADR_RSEL, 32'h1);
        @(posedge i_mclk);
        i_gpi <= 8'h01;
        i_pg_on <= 24'h000001;
        wait_for(0, 1'b1, 100);
        @(posedge i_mclk);
        i_pg_off <= 24'h000001;
        wait_for(0, 1'b0, 4);
        @(posedge i_mclk);
        i_pg_off <= 24'h000000;
        wait_for(0, 1'b1, 100);
        wr(ADR_DSEL, 32'h0);
        @(negedge i_mclk);
        chk("reconfig pulse", 32'(o_sys_rst_n), 32'h0);
        wait_for(0, 1'b1, 40);
        chk("zero delay", 32'(n < 30), 32'h1);
        $display("test release done");
    endtask : t_release

    task automatic t_wdog;
        wr(ADR_WDP, 32'h3);
        wr(ADR_MASK, 32'h1);
        host_en <= 1'b1;
        wr(ADR_CTRL, 32'h61);
        wait_for(0, 1'b1, 40);
        cnt = 0;
        repeat (150) @(negedge i_mclk) cnt += int'(o_timeout === 1'b1);
        chk("kicked no timeout", 32'(cnt), 32'h0);
        host_en <= 1'b0;
        wait_for(1, 1'b1, 80);
        wait_for(1, 1'b0, 40);
        chk("pulse width", 32'(n >= TK && n <= 2 * TK), 32'h1);
        chk("irq raised", 32'(o_irq), 32'h1);
        rdr(ADR_STAT);
        chk("timeout status", 32'(rd[SB_TIMEOUT]), 32'h1);
        chk("reset events", 32'(rd[SB_RST_RELEASE:SB_RST_ASSERT]), 32'h3);
        wr(ADR_STAT, 32'h1);
        @(negedge i_mclk);
        chk("irq cleared", 32'(o_irq), 32'h0);
        wr(ADR_KICK, 32'h1);
        rdr(ADR_WCNT);
        chk("bus kick count", 32'(rd <= 32'h1), 32'h1);
        wait_for(1, 1'b1, 80);
        wait_for(1, 1'b0, 40);
        host_en <= 1'b1;
        wr(ADR_CTRL, 32'h41);
        wait_for(0, 1'b1, 40);
        wr(ADR_KICK, 32'h1);
        wr(ADR_KICK, 32'h1);
        wait_for(1, 1'b1, 120);
        host_en <= 1'b0;
        $display("test supervision done");
    endtask : t_wdog

    // Start wait of 100 ms must hold off the first timeout.
    task automatic t_start;
        wait_for(1, 1'b0, 40);
        wr(ADR_CTRL, 32'h40);
        wr(ADR_CTRL, 32'h49);
        cnt = 0;
        repeat (900) @(negedge i_mclk) cnt += int'(o_timeout === 1'b1);
        chk("start wait quiet", 32'(cnt), 32'h0);
        wait_for(1, 1'b1, 200);
        $display("test start wait done");
    endtask : t_start

    // First pass releases through the fixed delay, second through tracking.
    task automatic t_route;
        for (int m = 0; m < 2; m++) begin
            wr(ADR_CTRL, (m == 0) ? 32'h03 : 32'h13);
            wait_for(0, 1'b1, 40);
            wr(ADR_KICK, 32'h1);
            wait_for(0, 1'b0, 80);
            chk("no pin pulse", 32'(o_timeout), 32'h0);
            wait_for(0, 1'b1, 60);
        end
        $display("test routed timeout done");
    endtask : t_route

    task automatic t_pulse;
        wr(ADR_PW, 32'h3);
        wr(ADR_CTRL, 32'h04);
        wait_for(0, 1'b1, 80);
        chk("pulse low time", 32'(n >= 20), 32'h1);
        cnt = 0;
        repeat (60) @(negedge i_mclk) cnt += int'(o_sys_rst_n !== 1'b1);
        chk("single pulse", 32'(cnt), 32'h0);
        $display("test pulse mode done");
    endtask : t_pulse

    initial begin
        i_rst = 1'b1;
        i_read = 1'b0;
        i_write = 1'b0;
        i_address = 8'h00;
        i_writedata = 32'h0;
        i_gpi = 8'h00;
        i_pg_on = 24'h000000;
        i_pg_off = 24'h000000;
        host_en = 1'b0;
        repeat (5) @(posedge i_mclk);
        i_rst <= 1'b0;
        t_regs();
        t_release();
        t_wdog();
        t_start();
        t_route();
        t_pulse();
        test_done();
    end
endmodule : testbench
`default_nettype wire
